/* File: logic/srr_params.svh */
// Named constants for the status reporting register bank
`ifndef SRR_PARAMS_SVH
`define SRR_PARAMS_SVH

// Register widths and group count
`define SRR_COND_W 15
`define SRR_REG_W 16
`define SRR_SEL_W 3
`define SRR_BYTE_W 8
`define SRR_GRP_N 2

// Register selectors carried by a command
`define SRR_SEL_COND 3'h0
`define SRR_SEL_FLAGS 3'h1
`define SRR_SEL_ENABLE 3'h2
`define SRR_SEL_PTR 3'h3
`define SRR_SEL_NTR 3'h4
`define SRR_SEL_PRESET 3'h5

// Group selectors
`define SRR_GRP_OPER 1'h0
`define SRR_GRP_QUES 1'h1

// Summary bit positions in the status byte
`define SRR_OSUM_BIT 7
`define SRR_QSUM_BIT 3

// Preset and reset values
`define SRR_ENA_PRESET 16'h0000
`define SRR_PTR_PRESET 15'h7fff
`define SRR_NTR_PRESET 15'h0000
`define SRR_ZERO_BIT 1'h0

`endif

/* File: logic/srr_pkg.sv */
// Types shared by the status reporting register bank
`include "srr_params.svh"

package srr_pkg;

    // Instrument command as issued by the remote controller
    typedef struct packed {
        logic valid;
        logic wr;
        logic grp;
        logic [`SRR_SEL_W-1:0] sel;
        logic [`SRR_REG_W-1:0] data;
    } srr_cmd_type;

    // Query answer
    typedef struct packed {
        logic valid;
        logic [`SRR_REG_W-1:0] data;
    } srr_rsp_type;

    // Strobes from the decoder into one group
    typedef struct packed {
        logic wr_ena;
        logic wr_ptr;
        logic wr_ntr;
        logic rd_clr;
        logic preset;
        logic [`SRR_REG_W-1:0] data;
    } srr_ctl_type;

    // Full state of one group
    typedef struct packed {
        logic [`SRR_COND_W-1:0] cond;
        logic [`SRR_COND_W-1:0] flags;
        logic [`SRR_REG_W-1:0] enable;
        logic [`SRR_COND_W-1:0] ptr;
        logic [`SRR_COND_W-1:0] ntr;
        logic summary;
    } srr_grp_type;

    // State of the top level
    typedef struct packed {
        srr_rsp_type rsp;
        logic [`SRR_BYTE_W-1:0] sum;
    } srr_top_type;

endpackage

/* File: logic/srr_group.sv */
// One status group: condition, transition filters, latched flags, mask
`timescale 1ns/1ps
`default_nettype none
`include "srr_params.svh"

module srr_group (
    input wire logic clock_i, // System clock
    input wire logic nrst_i, // Async reset, active low
    input wire logic [`SRR_COND_W-1:0] cond_i, // Live condition bits
    input wire srr_pkg::srr_ctl_type ctl_i, // Decoded strobes
    output srr_pkg::srr_grp_type view_o // Registered group state
);
    import srr_pkg::*;

    srr_grp_type st_reg;
    srr_grp_type st_next;
    logic [`SRR_COND_W-1:0] rise;
    logic [`SRR_COND_W-1:0] fall;
    logic [`SRR_COND_W-1:0] set_vec;

    // ****************************************
    // Transition detection
    // ****************************************
    assign rise = cond_i & ~st_reg.cond;
    assign fall = ~cond_i & st_reg.cond;
    assign set_vec = (rise & st_reg.ptr) | (fall & st_reg.ntr);

    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.cond = cond_i;
        if (ctl_i.preset) begin
            st_next.enable = `SRR_ENA_PRESET;
            st_next.ptr = `SRR_PTR_PRESET;
            st_next.ntr = `SRR_NTR_PRESET;
        end else begin
            if (ctl_i.wr_ena) begin
                st_next.enable = ctl_i.data;
            end
            if (ctl_i.wr_ptr) begin
                st_next.ptr = ctl_i.data[`SRR_COND_W-1:0];
            end
            if (ctl_i.wr_ntr) begin
                st_next.ntr = ctl_i.data[`SRR_COND_W-1:0];
            end
        end
        // New events win over a clearing read
        st_next.flags = (ctl_i.rd_clr ? '0 : st_reg.flags) | set_vec;
        st_next.summary = |(st_next.flags & st_next.enable[`SRR_COND_W-1:0]);
    end

    // State register
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '{cond: '0, flags: '0, enable: `SRR_ENA_PRESET,
                        ptr: `SRR_PTR_PRESET, ntr: `SRR_NTR_PRESET, summary: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign view_o = st_reg;

    // ****************************************
    // Assertions
    // ****************************************
    a_rise_latch: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ((cond_i & ~st_reg.cond & st_reg.ptr) != '0)
        |=> ((st_reg.flags & $past(cond_i & ~st_reg.cond & st_reg.ptr))
             == $past(cond_i & ~st_reg.cond & st_reg.ptr)))
        else $error("rising edge not latched");
    a_fall_latch: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ((~cond_i & st_reg.cond & st_reg.ntr) != '0)
        |=> ((st_reg.flags & $past(~cond_i & st_reg.cond & st_reg.ntr))
             == $past(~cond_i & st_reg.cond & st_reg.ntr)))
        else $error("falling edge not latched");
    a_read_clear: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (ctl_i.rd_clr && set_vec == '0) |=> (st_reg.flags == '0))
        else $error("flags not cleared by read");
    a_preset_load: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ctl_i.preset |=> (st_reg.enable == `SRR_ENA_PRESET && st_reg.ptr == `SRR_PTR_PRESET
                          && st_reg.ntr == `SRR_NTR_PRESET))
        else $error("preset values not loaded");
    a_mask_store: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (ctl_i.wr_ena && !ctl_i.preset) |=> (st_reg.enable == $past(ctl_i.data)))
        else $error("enable mask not stored");

endmodule
`default_nettype wire

/* File: logic/srr_top.sv */
// Status reporting register bank with operation and questionable groups
`timescale 1ns/1ps
`default_nettype none
`include "srr_params.svh"

// Summary of operation
// - Two groups, each with five registers
// - Condition read returns live value, no change
// - Enable mask written and read back intact
// - Questionable enabled flag sets byte bit 3
// - Operation enabled flag sets byte bit 7
// - Flags read returns latched events
// - Flags read clears the flags register
// - Filtered rising condition latches flag bit
// - Filtered falling condition latches flag bit
// - Preset loads masks, rising and falling filters
module srr_top (
    input wire logic clock_i, // System clock, 200 MHz
    input wire logic nrst_i, // Async reset, active low
    input wire logic [`SRR_COND_W-1:0] oper_cond_i, // Operation condition bits
    input wire logic [`SRR_COND_W-1:0] ques_cond_i, // Questionable condition bits
    input wire srr_pkg::srr_cmd_type cmd_i, // Instrument command
    output srr_pkg::srr_rsp_type rsp_o, // Query answer
    output logic [`SRR_BYTE_W-1:0] summary_byte_o // Status byte summary bits
);
    import srr_pkg::*;

    srr_top_type st_reg;
    srr_top_type st_next;
    srr_grp_type [`SRR_GRP_N-1:0] view;
    srr_ctl_type [`SRR_GRP_N-1:0] ctl;
    logic [`SRR_GRP_N-1:0][`SRR_COND_W-1:0] cond;
    srr_grp_type rd_view;
    logic is_read;
    logic is_write;

    // ****************************************
    // Command decode
    // ****************************************

    // Command qualifiers
    assign is_read = cmd_i.valid && !cmd_i.wr;
    assign is_write = cmd_i.valid && cmd_i.wr;
    assign cond[`SRR_GRP_OPER] = oper_cond_i;
    assign cond[`SRR_GRP_QUES] = ques_cond_i;

    // One status group per index
    for (genvar g = 0; g < `SRR_GRP_N; g++) begin : g_grp
        // Strobes for this group; preset reaches both groups
        assign ctl[g].preset = is_write && (cmd_i.sel == `SRR_SEL_PRESET);
        assign ctl[g].wr_ena = is_write && (cmd_i.grp == 1'(g))
                               && (cmd_i.sel == `SRR_SEL_ENABLE);
        assign ctl[g].wr_ptr = is_write && (cmd_i.grp == 1'(g))
                               && (cmd_i.sel == `SRR_SEL_PTR);
        assign ctl[g].wr_ntr = is_write && (cmd_i.grp == 1'(g))
                               && (cmd_i.sel == `SRR_SEL_NTR);
        assign ctl[g].rd_clr = is_read && (cmd_i.grp == 1'(g))
                               && (cmd_i.sel == `SRR_SEL_FLAGS);
        assign ctl[g].data = cmd_i.data;

        srr_group u_group (
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .cond_i(cond[g]),
            .ctl_i(ctl[g]),
            .view_o(view[g])
        );
    end

    // Group addressed by the current query
    assign rd_view = view[cmd_i.grp];

    // ****************************************
    // Answer and summary byte
    // ****************************************

    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.rsp.valid = 1'b0;
        if (is_read) begin
            st_next.rsp.valid = 1'b1;
            if (cmd_i.sel == `SRR_SEL_COND) begin
                st_next.rsp.data = {`SRR_ZERO_BIT, rd_view.cond};
            end else if (cmd_i.sel == `SRR_SEL_FLAGS) begin
                st_next.rsp.data = {`SRR_ZERO_BIT, rd_view.flags};
            end else if (cmd_i.sel == `SRR_SEL_ENABLE) begin
                st_next.rsp.data = rd_view.enable;
            end else if (cmd_i.sel == `SRR_SEL_PTR) begin
                st_next.rsp.data = {`SRR_ZERO_BIT, rd_view.ptr};
            end else if (cmd_i.sel == `SRR_SEL_NTR) begin
                st_next.rsp.data = {`SRR_ZERO_BIT, rd_view.ntr};
            end else begin
                st_next.rsp.data = '0;
            end
        end
        // Only the two summary bits are owned here
        st_next.sum = '0;
        st_next.sum[`SRR_OSUM_BIT] = view[`SRR_GRP_OPER].summary;
        st_next.sum[`SRR_QSUM_BIT] = view[`SRR_GRP_QUES].summary;
    end

    // State register
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '{rsp: '{valid: 1'b0, data: '0}, sum: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign rsp_o = st_reg.rsp;
    assign summary_byte_o = st_reg.sum;

    // ****************************************
    // Assertions
    // ****************************************

    // Enable write followed at once by a read of the same mask
    sequence s_ena_write_read;
        (is_write && cmd_i.sel == `SRR_SEL_ENABLE)
        ##1 (is_read && cmd_i.sel == `SRR_SEL_ENABLE && cmd_i.grp == $past(cmd_i.grp));
    endsequence

    // Flags query
    sequence s_flags_query;
        is_read && cmd_i.sel == `SRR_SEL_FLAGS;
    endsequence

    a_enable_back: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_ena_write_read |=> (rsp_o.valid && rsp_o.data == $past(cmd_i.data, 2)))
        else $error("enable mask not read back");

    a_oper_summary: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (|(view[`SRR_GRP_OPER].flags & view[`SRR_GRP_OPER].enable[`SRR_COND_W-1:0]))
        |=> summary_byte_o[`SRR_OSUM_BIT])
        else $error("operation summary not set");

    a_ques_summary: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (|(view[`SRR_GRP_QUES].flags & view[`SRR_GRP_QUES].enable[`SRR_COND_W-1:0]))
        |=> summary_byte_o[`SRR_QSUM_BIT])
        else $error("questionable summary not set");

    a_summary_clear: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !(|(view[`SRR_GRP_QUES].flags & view[`SRR_GRP_QUES].enable[`SRR_COND_W-1:0]))
        |=> !summary_byte_o[`SRR_QSUM_BIT])
        else $error("questionable summary stuck");

    a_cond_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (is_read && cmd_i.sel == `SRR_SEL_COND)
        |=> (rsp_o.valid && rsp_o.data == {`SRR_ZERO_BIT, $past(rd_view.cond)}))
        else $error("condition read wrong");

    a_flags_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_flags_query |=> (rsp_o.valid && rsp_o.data == {`SRR_ZERO_BIT, $past(rd_view.flags)}))
        else $error("flags read wrong");

    a_bit15_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (rsp_o.valid && $past(cmd_i.sel) != `SRR_SEL_ENABLE) |-> !rsp_o.data[`SRR_COND_W])
        else $error("top bit not zero");

    a_write_silent: assert property (@(posedge clock_i) disable iff (!nrst_i)
        is_write |=> !rsp_o.valid)
        else $error("write produced an answer");

    a_byte_other: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (summary_byte_o & ~((`SRR_BYTE_W'(1) << `SRR_OSUM_BIT)
                            | (`SRR_BYTE_W'(1) << `SRR_QSUM_BIT))) == '0)
        else $error("foreign status byte bit set");

    a_oper_clear: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !(|(view[`SRR_GRP_OPER].flags & view[`SRR_GRP_OPER].enable[`SRR_COND_W-1:0]))
        |=> !summary_byte_o[`SRR_OSUM_BIT])
        else $error("operation summary stuck");

    // Every query answers on the next edge
    a_query_answer: assert property (@(posedge clock_i) disable iff (!nrst_i)
        is_read |=> rsp_o.valid)
        else $error("query gave no answer");

    // Without a query the answer register keeps its word
    a_answer_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !is_read |=> (!rsp_o.valid && rsp_o.data == $past(rsp_o.data)))
        else $error("answer changed without a query");

    a_enable_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (is_read && cmd_i.sel == `SRR_SEL_ENABLE)
        |=> (rsp_o.data == $past(rd_view.enable)))
        else $error("enable mask read wrong");

    // Selector that names no register
    sequence s_unused_query;
        is_read && cmd_i.sel != `SRR_SEL_COND && cmd_i.sel != `SRR_SEL_FLAGS
            && cmd_i.sel != `SRR_SEL_ENABLE && cmd_i.sel != `SRR_SEL_PTR
            && cmd_i.sel != `SRR_SEL_NTR;
    endsequence

    a_unused_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_unused_query |=> (rsp_o.valid && rsp_o.data == '0))
        else $error("unused selector answered nonzero");

    // Condition query, which must leave masks and latched flags alone
    sequence s_cond_query;
        is_read && cmd_i.sel == `SRR_SEL_COND;
    endsequence

    a_cond_keeps: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cond_query |=> (view[`SRR_GRP_OPER].enable == $past(view[`SRR_GRP_OPER].enable)
            && view[`SRR_GRP_QUES].enable == $past(view[`SRR_GRP_QUES].enable)
            && (view[`SRR_GRP_OPER].flags & $past(view[`SRR_GRP_OPER].flags))
               == $past(view[`SRR_GRP_OPER].flags)
            && (view[`SRR_GRP_QUES].flags & $past(view[`SRR_GRP_QUES].flags))
               == $past(view[`SRR_GRP_QUES].flags)))
        else $error("condition read altered a register");

    // A non-preset write to the questionable group leaves the operation group untouched
    a_group_apart: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (is_write && cmd_i.grp == `SRR_GRP_QUES && cmd_i.sel != `SRR_SEL_PRESET)
        |=> (view[`SRR_GRP_OPER].enable == $past(view[`SRR_GRP_OPER].enable)
             && view[`SRR_GRP_OPER].ptr == $past(view[`SRR_GRP_OPER].ptr)
             && view[`SRR_GRP_OPER].ntr == $past(view[`SRR_GRP_OPER].ntr)))
        else $error("write reached the other group");

endmodule
`default_nettype wire

/* File: verif/srr_ctrl_model.sv */
// Remote controller model: issues instrument commands and drives condition bits
`timescale 1ns/1ps
`default_nettype none
`include "srr_params.svh"

module srr_ctrl_model (
    input wire logic clock_i, // System clock
    input wire srr_pkg::srr_rsp_type rsp_i, // Query answer
    output srr_pkg::srr_cmd_type cmd_o, // Instrument command
    output logic [`SRR_COND_W-1:0] oper_cond_o, // Operation condition bits
    output logic [`SRR_COND_W-1:0] ques_cond_o // Questionable condition bits
);
    import srr_pkg::*;

    // Idle command port and quiet conditions at start
    initial begin
        cmd_o = '0;
        oper_cond_o = 15'h0000;
        ques_cond_o = 15'h0000;
    end

    // One command pulse held through its taking edge
    task automatic send(input logic wr, input logic grp, input logic [`SRR_SEL_W-1:0] sel,
                        input logic [`SRR_REG_W-1:0] data);
        @(posedge clock_i);
        #1;
        cmd_o = {1'b1, wr, grp, sel, data};
        @(posedge clock_i);
        #1;
        cmd_o = {1'b0, wr, grp, sel, ~data}; // Stale data must not be trusted
    endtask

    // Query, answer taken in the cycle it stands
    task automatic query(input logic grp, input logic [`SRR_SEL_W-1:0] sel,
                         output logic [`SRR_REG_W-1:0] data);
        send(1'b0, grp, sel, 16'h0000);
        data = (rsp_i.valid === 1'b1) ? rsp_i.data : 'x;
    endtask

    // Write then query on the next edge, valid held up across both
    task automatic write_query(input logic grp, input logic [`SRR_SEL_W-1:0] sel,
                               input logic [`SRR_REG_W-1:0] wdata,
                               output logic [`SRR_REG_W-1:0] data);
        @(posedge clock_i);
        #1;
        cmd_o = {1'b1, 1'b1, grp, sel, wdata};
        @(posedge clock_i);
        #1;
        cmd_o = {1'b1, 1'b0, grp, sel, 16'h0000};
        @(posedge clock_i);
        #1;
        cmd_o = {1'b0, 1'b0, grp, sel, ~wdata};
        data = (rsp_i.valid === 1'b1) ? rsp_i.data : 'x;
    endtask

    // New live condition value for one group
    task automatic set_cond(input logic grp, input logic [`SRR_COND_W-1:0] v);
        @(posedge clock_i);
        #1;
        if (grp) begin
            ques_cond_o = v;
        end else begin
            oper_cond_o = v;
        end
    endtask
endmodule
`default_nettype wire

/* File: verif/srr_top_test.sv */
// Self-checking testbench for the status reporting register bank
`timescale 1ns/1ps
`default_nettype none
`include "srr_params.svh"

module srr_top_test;
    import srr_pkg::*;

    logic clock_i;
    logic nrst_i;
    srr_cmd_type cmd;
    srr_rsp_type rsp;
    logic [`SRR_COND_W-1:0] oc;
    logic [`SRR_COND_W-1:0] qc;
    logic [`SRR_BYTE_W-1:0] sb;
    logic [`SRR_REG_W-1:0] rd;
    logic [`SRR_BYTE_W-1:0] sum_exp;
    logic gb;
    int bad_count;
    int checks;

    srr_top i_srr_top (.clock_i(clock_i), .nrst_i(nrst_i), .oper_cond_i(oc), .ques_cond_i(qc),
        .cmd_i(cmd), .rsp_o(rsp), .summary_byte_o(sb));

    srr_ctrl_model i_srr_ctrl_model (.clock_i(clock_i), .rsp_i(rsp), .cmd_o(cmd),
        .oper_cond_o(oc), .ques_cond_o(qc));

    // 200 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic g, input logic [2:0] s, input logic [15:0] exp);
        i_srr_ctrl_model.query(g, s, rd);
        check(rd, exp);
    endtask

    task automatic wr(input logic g, input logic [2:0] s, input logic [15:0] d);
        i_srr_ctrl_model.send(1'b1, g, s, d);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic tally_and_finish();
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #20000;
        bad_count++;
        tally_and_finish();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        bad_count = 0;
        checks = 0;
        nrst_i = 1'b0;
        repeat (20) @(posedge clock_i);
        #1;
        nrst_i = 1'b1;
        for (int g = 0; g < 2; g++) begin
            gb = g[0];
            sum_exp = gb ? 8'h08 : 8'h80;
            rd_chk(gb, `SRR_SEL_ENABLE, 16'h0000);
            rd_chk(gb, `SRR_SEL_PTR, 16'h7fff);
            rd_chk(gb, `SRR_SEL_NTR, 16'h0000);
            rd_chk(gb, `SRR_SEL_FLAGS, 16'h0000);
            wr(gb, `SRR_SEL_ENABLE, 16'hffff);
            rd_chk(gb, `SRR_SEL_ENABLE, 16'hffff);
            // Write and query on back-to-back edges
            i_srr_ctrl_model.write_query(gb, `SRR_SEL_ENABLE, 16'h8001, rd);
            check(rd, 16'h8001);
            wr(gb, `SRR_SEL_PTR, 16'hffff);
            rd_chk(gb, `SRR_SEL_PTR, 16'h7fff);
            wr(gb, `SRR_SEL_ENABLE, 16'h0000);
            // Rising edges through the full rising filter
            i_srr_ctrl_model.set_cond(gb, 15'h1234);
            idle(2);
            rd_chk(gb, `SRR_SEL_COND, 16'h1234);
            rd_chk(gb, `SRR_SEL_COND, 16'h1234);
            rd_chk(gb, `SRR_SEL_FLAGS, 16'h1234);
            rd_chk(gb, `SRR_SEL_FLAGS, 16'h0000);
            // Falling edges through a partial falling filter only
            wr(gb, `SRR_SEL_PTR, 16'h0000);
            wr(gb, `SRR_SEL_NTR, 16'h00f0);
            i_srr_ctrl_model.set_cond(gb, 15'h0004);
            idle(2);
            rd_chk(gb, `SRR_SEL_FLAGS, 16'h0030);
            // Summary bit needs an enabled flag
            wr(gb, `SRR_SEL_ENABLE, 16'h0010);
            wr(gb, `SRR_SEL_PTR, 16'h0020);
            i_srr_ctrl_model.set_cond(gb, 15'h0024);
            idle(3);
            check({8'h00, sb}, 16'h0000);
            wr(gb, `SRR_SEL_ENABLE, 16'h0030);
            idle(3);
            check({8'h00, sb}, {8'h00, sum_exp});
            rd_chk(gb, `SRR_SEL_FLAGS, 16'h0020);
            idle(3);
            check({8'h00, sb}, 16'h0000);
        end
        // Preset reloads masks and filters of both groups
        wr(1'b0, `SRR_SEL_PRESET, 16'h0000);
        for (int g = 0; g < 2; g++) begin
            gb = g[0];
            rd_chk(gb, `SRR_SEL_ENABLE, 16'h0000);
            rd_chk(gb, `SRR_SEL_PTR, 16'h7fff);
            rd_chk(gb, `SRR_SEL_NTR, 16'h0000);
        end
        rd_chk(1'b0, 3'h6, 16'h0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
